// *** common/ddr_link_if.sv ***
`timescale 1ns/1ps
interface ddr_link_if #(parameter int DQ_W = 16);
	logic            ck;
	logic            cs_n;
	logic            ras_n;
	logic            cas_n;
	logic            we_n;
	logic            odt;
	logic [2:0]      ba;
	logic [13:0]     addr;
	logic            dqs_c_o;
	logic            dqs_c_oe;
	logic            dqs_d_o;
	logic            dqs_d_oe;
	logic [DQ_W-1:0] dq_d_o;
	logic            dq_d_oe;
	logic            dqs;
	logic [DQ_W-1:0] dq;

	// Undriven lines settle low through the board termination
	assign dqs = dqs_c_oe ? dqs_c_o : (dqs_d_oe & dqs_d_o);
	assign dq  = dq_d_oe ? dq_d_o : '0;

	modport ctrl (output ck, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dqs_c_o, dqs_c_oe,
		input dqs, dq);
	modport dram (input ck, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dqs,
		output dqs_d_o, dqs_d_oe, dq_d_o, dq_d_oe);
endinterface : ddr_link_if

// *** common/ddr_link_pkg.sv ***
package ddr_link_pkg;
// Behaviour
// - Controller stops strobe after last leveling edge
// - Data pins undefined until mode delay elapses
// - Controller drives termination low and keeps it
// - Leveling-off mode command only after termination off
// - Any command after mode delay from exit
// - Mode commands allowed after mode cycle delay
// - Burst length selectable per read or write
// - Address bit 12 low chop four, high eight
// - Address bit 12 never part of column
// - Eight beats on fixed-8 or on-the-fly plus bit12
// - Read latency is additive plus CAS latency
// - Read to precharge spacing additive plus internal delay
// - Activate to precharge time also respected
// - Internal read-to-precharge at least 4 clocks, 7.5 ns
// - Activate needs precharge time and row cycle
// - Strobe at latency minus one, data at latency
// - Release at latency plus four or two clocks
// - Read timing only with delay loop locked
// - Mode register 1 bit 7 enters leveling
// - Only mode commands while leveling

	localparam int CK_HALF       = 4;
	localparam int CLK_PERIOD_PS = 100000;
	localparam int CK_PERIOD_PS  = 2 * CK_HALF * CLK_PERIOD_PS;
	localparam int TRTP_PS       = 7500;
	localparam int TRTP_MIN_CK   = 4;
	localparam int TRTP_NS_CK    = (TRTP_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
	localparam int TRTP_CK       = (TRTP_NS_CK > TRTP_MIN_CK) ? TRTP_NS_CK : TRTP_MIN_CK;
	localparam int TRAS_CK       = 15;
	localparam int TRP_CK        = 6;
	localparam int TRC_CK        = 21;
	localparam int TMOD_CK       = 12;
	localparam int TMRD_CK       = 4;
	localparam int TAOF_CK       = 9;
	localparam int NBANK         = 8;
	localparam int PIPE          = 32;

	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_RD  = 3'h5;
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] OP_WLX  = 3'h4;

	localparam logic [1:0] BL_FIX8   = 2'h0;
	localparam logic [1:0] BL_OTF    = 2'h1;
	localparam int         MR0_CL    = 4;
	localparam int         MR1_AL    = 3;
	localparam int         MR1_WL    = 7;
	localparam int         A_BL      = 12;
	localparam logic [3:0] BEATS8    = 4'h8;
	localparam logic [3:0] BEATS4    = 4'h4;
	localparam logic [2:0] BA_MR0    = 3'h0;
	localparam logic [2:0] BA_MR1    = 3'h1;

	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_CMD   = 8'h04;
	localparam logic [7:0] REG_STAT  = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam int         CTRL_ODT  = 0;
	localparam int         CTRL_DQS  = 1;
	localparam int         CTRL_LVL  = 2;
	localparam int         CMD_BANK  = 4;
	localparam int         CMD_ADDR  = 16;

	function automatic logic [4:0] al_of(input logic [1:0] code, input logic [3:0] cl);
		case (code)
			2'h1:    return {1'b0, cl} - 5'h01;
			2'h2:    return {1'b0, cl} - 5'h02;
			default: return 5'h00;
		endcase
	endfunction : al_of

	function automatic logic [4:0] rl_of(input logic [1:0] code, input logic [3:0] cl);
		return al_of(code, cl) + {1'b0, cl};
	endfunction : rl_of

	function automatic logic [3:0] beats_of(input logic [1:0] mode, input logic a12);
		return ((mode == BL_FIX8) || ((mode == BL_OTF) && a12)) ? BEATS8 : BEATS4;
	endfunction : beats_of
endpackage : ddr_link_pkg

// *** rtl/bank_timer.sv ***
`timescale 1ns/1ps
module bank_timer #(
	parameter int TRAS = 15,
	parameter int TRP  = 6,
	parameter int TRC  = 21
)(
	// System
	input  logic       clk,
	input  logic       reset_n,
	input  logic       ce,
	// Events, all on link-cycle ticks
	input  logic       tick,
	input  logic       act,
	input  logic       rd,
	input  logic       pre,
	input  logic [5:0] rd_gap,
	// Permissions
	output logic       pre_ok,
	output logic       act_ok
);
	logic [5:0] ras_r, ras_nxt, rp_r, rp_nxt, rc_r, rc_nxt, rtp_r, rtp_nxt;

	function automatic logic [5:0] dec(input logic [5:0] v);
		return (v != 6'h00) ? v - 6'h01 : v;
	endfunction : dec

	// A count of n allows the next command n ticks after the load
	assign pre_ok = (ras_r <= 6'h01) && (rtp_r <= 6'h01);
	assign act_ok = (rp_r <= 6'h01) && (rc_r <= 6'h01);

	always_comb begin
		ras_nxt = ras_r;
		rp_nxt  = rp_r;
		rc_nxt  = rc_r;
		rtp_nxt = rtp_r;
		if (tick) begin
			ras_nxt = dec(ras_r);
			rp_nxt  = dec(rp_r);
			rc_nxt  = dec(rc_r);
			rtp_nxt = dec(rtp_r);
			if (act) begin
				ras_nxt = 6'(TRAS);
				rc_nxt  = 6'(TRC);
			end
			if (pre)
				rp_nxt = 6'(TRP);
			if (rd)
				rtp_nxt = rd_gap;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ras_r <= 6'h00;
			rp_r  <= 6'h00;
			rc_r  <= 6'h00;
			rtp_r <= 6'h00;
		end else if (ce) begin
			ras_r <= ras_nxt;
			rp_r  <= rp_nxt;
			rc_r  <= rc_nxt;
			rtp_r <= rtp_nxt;
		end
	end
endmodule : bank_timer

// *** rtl/ddr_ctrl_end.sv ***
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module ddr_ctrl_end #(
	parameter int DQ_W = 16,
	parameter int TRAS = ddr_link_pkg::TRAS_CK,
	parameter int TRP  = ddr_link_pkg::TRP_CK,
	parameter int TRC  = ddr_link_pkg::TRC_CK,
	parameter int TMOD = ddr_link_pkg::TMOD_CK,
	parameter int TMRD = ddr_link_pkg::TMRD_CK,
	parameter int TAOF = ddr_link_pkg::TAOF_CK
)(
	// System
	input  logic        clk,
	input  logic        reset_n,
	input  logic        ce,
	// APB slave
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [7:0]  paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	// Link
	ddr_link_if.ctrl    lnk
);
	typedef enum logic [2:0] {
		S_IDLE = 3'h1,
		S_WAIT = 3'h2,
		S_ODT  = 3'h4
	} state_t;

	localparam int NB = ddr_link_pkg::NBANK;

	state_t      state_r, state_nxt;
	logic [2:0]  div_r, div_nxt;
	logic        ck_r, fall;
	logic [2:0]  op_r, op_nxt, bank_r, bank_nxt, cmd_r, cmd_nxt, ba_r, ba_nxt;
	logic [13:0] adr_r, adr_nxt, out_a_r, out_a_nxt, mr0_r, mr0_nxt, mr1_r, mr1_nxt;
	logic [5:0]  mod_r, mod_nxt, mrd_r, mrd_nxt, aof_r, aof_nxt;
	logic        wl_r, wl_nxt, lock_r, lock_nxt, err_r, err_nxt;
	logic [2:0]  ctl_r, ctl_nxt;
	logic        odt_r, odt_nxt, dqs_oe_r, dqs_oe_nxt, dqs_r, dqs_nxt;
	logic        wr_acc, wr_cmd, busy, any_ok, mrs_ok, rd_iss;
	logic [NB-1:0] pre_ok, act_ok, hit;
	logic [5:0]  rd_gap;
	logic        dqs1_r, dqs2_r, dqs3_r;
	logic [DQ_W-1:0] dq1_r, dq2_r;
	logic [3:0]  left_r, left_nxt;
	logic [2:0]  idx_r, idx_nxt;
	logic        rdv_r, rdv_nxt;
	logic [DQ_W-1:0] rb_r [8], rb_nxt [8];
	logic [31:0] prd_r, prd_nxt;

	assign fall   = (div_r == 3'(ddr_link_pkg::CK_HALF - 1));
	assign wr_acc = psel & penable & pwrite;
	assign wr_cmd = wr_acc && paddr == ddr_link_pkg::REG_CMD;
	assign busy   = state_r != S_IDLE;
	assign any_ok = mod_r <= 6'h01;
	assign mrs_ok = mrd_r <= 6'h01;
	assign rd_iss = fall && state_r == S_WAIT && op_r == ddr_link_pkg::CMD_RD && any_ok && !wl_r;
	// Internal read-to-precharge counts from the end of the additive delay
	assign rd_gap = 6'(ddr_link_pkg::al_of(mr1_r[ddr_link_pkg::MR1_AL +: 2],
		mr0_r[ddr_link_pkg::MR0_CL +: 4])) + 6'(ddr_link_pkg::TRTP_CK);

	for (genvar b = 0; b < NB; b++) begin : g_bank
		bank_timer #(.TRAS(TRAS), .TRP(TRP), .TRC(TRC)) u_tmr (
			.clk    (clk),
			.reset_n(reset_n),
			.ce     (ce),
			.tick   (fall),
			.act    (hit[b] && cmd_nxt == ddr_link_pkg::CMD_ACT),
			.rd     (hit[b] && cmd_nxt == ddr_link_pkg::CMD_RD),
			.pre    (hit[b] && cmd_nxt == ddr_link_pkg::CMD_PRE),
			.rd_gap (rd_gap),
			.pre_ok (pre_ok[b]),
			.act_ok (act_ok[b])
		);
		assign hit[b] = fall && (ba_nxt == 3'(b));
	end

	// Command sequencer; the link changes while ck is low so the far end sees it settled
	always_comb begin
		div_nxt    = (div_r == 3'(2 * ddr_link_pkg::CK_HALF - 1)) ? 3'h0 : div_r + 3'h1;
		state_nxt  = state_r;
		op_nxt     = op_r;
		bank_nxt   = bank_r;
		adr_nxt    = adr_r;
		cmd_nxt    = cmd_r;
		ba_nxt     = ba_r;
		out_a_nxt  = out_a_r;
		mr0_nxt    = mr0_r;
		mr1_nxt    = mr1_r;
		mod_nxt    = mod_r;
		mrd_nxt    = mrd_r;
		aof_nxt    = aof_r;
		wl_nxt     = wl_r;
		lock_nxt   = lock_r;
		err_nxt    = err_r;
		ctl_nxt    = ctl_r;
		if (wr_acc && paddr == ddr_link_pkg::REG_CTRL) begin
			ctl_nxt  = pwdata[2:0];
			lock_nxt = 1'b0;
		end
		if (wr_cmd && !busy) begin
			op_nxt    = pwdata[2:0];
			bank_nxt  = pwdata[ddr_link_pkg::CMD_BANK +: 3];
			adr_nxt   = pwdata[ddr_link_pkg::CMD_ADDR +: 14];
			err_nxt   = 1'b0;
			state_nxt = S_WAIT;
		end
		if (fall) begin
			cmd_nxt = ddr_link_pkg::CMD_NOP;
			mod_nxt = (mod_r != 6'h00) ? mod_r - 6'h01 : mod_r;
			mrd_nxt = (mrd_r != 6'h00) ? mrd_r - 6'h01 : mrd_r;
			aof_nxt = (aof_r != 6'h00) ? aof_r - 6'h01 : aof_r;
			case (state_r)
				S_WAIT: begin
					if (wl_r && op_r != ddr_link_pkg::CMD_MRS && op_r != ddr_link_pkg::OP_WLX) begin
						err_nxt   = 1'b1;
						state_nxt = S_IDLE;
					end else if (op_r == ddr_link_pkg::OP_WLX) begin
						err_nxt   = !wl_r;
						lock_nxt  = wl_r;
						aof_nxt   = 6'(TAOF);
						state_nxt = wl_r ? S_ODT : S_IDLE;
					end else if (op_r == ddr_link_pkg::CMD_MRS ? mrs_ok :
						(any_ok && (op_r == ddr_link_pkg::CMD_RD ||
						(op_r == ddr_link_pkg::CMD_PRE && pre_ok[bank_r]) ||
						(op_r == ddr_link_pkg::CMD_ACT && act_ok[bank_r])))) begin
						cmd_nxt   = op_r;
						ba_nxt    = bank_r;
						out_a_nxt = adr_r;
						state_nxt = S_IDLE;
						if (op_r == ddr_link_pkg::CMD_MRS) begin
							mod_nxt = 6'(TMOD);
							mrd_nxt = 6'(TMRD);
							if (bank_r == ddr_link_pkg::BA_MR0)
								mr0_nxt = adr_r;
							if (bank_r == ddr_link_pkg::BA_MR1) begin
								mr1_nxt = adr_r;
								wl_nxt  = adr_r[ddr_link_pkg::MR1_WL];
							end
						end else if (op_r != ddr_link_pkg::CMD_RD &&
							op_r != ddr_link_pkg::CMD_PRE && op_r != ddr_link_pkg::CMD_ACT) begin
							cmd_nxt = ddr_link_pkg::CMD_NOP;
							err_nxt = 1'b1;
						end
					end
				end
				S_ODT: begin
					if (aof_r <= 6'h01 && mrs_ok) begin
						cmd_nxt   = ddr_link_pkg::CMD_MRS;
						ba_nxt    = ddr_link_pkg::BA_MR1;
						out_a_nxt = mr1_r & ~(14'h0001 << ddr_link_pkg::MR1_WL);
						mr1_nxt   = out_a_nxt;
						wl_nxt    = 1'b0;
						mod_nxt   = 6'(TMOD);
						mrd_nxt   = 6'(TMRD);
						state_nxt = S_IDLE;
					end
				end
				default: ;
			endcase
		end
		// Once released for exit, strobe and termination stay off until software rewrites control or orders OP_WLX outside leveling
		odt_nxt    = ctl_nxt[ddr_link_pkg::CTRL_ODT] & ~lock_nxt;
		dqs_oe_nxt = ctl_nxt[ddr_link_pkg::CTRL_DQS] & wl_nxt & ~lock_nxt;
		dqs_nxt    = ctl_nxt[ddr_link_pkg::CTRL_LVL];
	end

	// Read capture on both strobe edges
	always_comb begin
		left_nxt = left_r;
		idx_nxt  = idx_r;
		rdv_nxt  = rdv_r;
		rb_nxt   = rb_r;
		if (rd_iss) begin
			left_nxt = ddr_link_pkg::beats_of(mr0_r[1:0], adr_r[ddr_link_pkg::A_BL]);
			idx_nxt  = 3'h0;
			rdv_nxt  = 1'b0;
		end else if ((dqs2_r ^ dqs3_r) && left_r != 4'h0) begin
			rb_nxt[idx_r] = dq2_r;
			idx_nxt       = idx_r + 3'h1;
			left_nxt      = left_r - 4'h1;
			rdv_nxt       = (left_r == 4'h1);
		end
		prd_nxt = 32'h00000000;
		case (paddr)
			ddr_link_pkg::REG_CTRL: prd_nxt = {29'h0, ctl_r};
			ddr_link_pkg::REG_CMD:  prd_nxt = {2'h0, adr_r, 9'h0, bank_r, 1'b0, op_r};
			ddr_link_pkg::REG_STAT: prd_nxt = {28'h0, rdv_r, err_r, wl_r, busy};
			default: begin
				if (paddr[7:4] == ddr_link_pkg::REG_RDATA[7:4] && paddr[1:0] == 2'h0)
					prd_nxt = {rb_r[{paddr[3:2], 1'b1}], rb_r[{paddr[3:2], 1'b0}]};
			end
		endcase
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ((wr_cmd & busy) |
		~(paddr[7:4] == ddr_link_pkg::REG_RDATA[7:4] || paddr == ddr_link_pkg::REG_CTRL ||
		paddr == ddr_link_pkg::REG_CMD || paddr == ddr_link_pkg::REG_STAT));

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_r  <= S_IDLE;
			div_r    <= 3'h0;
			ck_r     <= 1'b0;
			op_r     <= ddr_link_pkg::CMD_NOP;
			bank_r   <= 3'h0;
			adr_r    <= 14'h0000;
			cmd_r    <= ddr_link_pkg::CMD_NOP;
			ba_r     <= 3'h0;
			out_a_r  <= 14'h0000;
			mr0_r    <= 14'h0000;
			mr1_r    <= 14'h0000;
			mod_r    <= 6'h00;
			mrd_r    <= 6'h00;
			aof_r    <= 6'h00;
			wl_r     <= 1'b0;
			lock_r   <= 1'b0;
			err_r    <= 1'b0;
			ctl_r    <= 3'h0;
			odt_r    <= 1'b0;
			dqs_oe_r <= 1'b0;
			dqs_r    <= 1'b0;
			dqs1_r   <= 1'b0;
			dqs2_r   <= 1'b0;
			dqs3_r   <= 1'b0;
			dq1_r    <= '0;
			dq2_r    <= '0;
			left_r   <= 4'h0;
			idx_r    <= 3'h0;
			rdv_r    <= 1'b0;
			prd_r    <= 32'h00000000;
			for (int i = 0; i < 8; i++)
				rb_r[i] <= '0;
		end else if (ce) begin
			state_r  <= state_nxt;
			div_r    <= div_nxt;
			ck_r     <= div_nxt < 3'(ddr_link_pkg::CK_HALF);
			op_r     <= op_nxt;
			bank_r   <= bank_nxt;
			adr_r    <= adr_nxt;
			cmd_r    <= cmd_nxt;
			ba_r     <= ba_nxt;
			out_a_r  <= out_a_nxt;
			mr0_r    <= mr0_nxt;
			mr1_r    <= mr1_nxt;
			mod_r    <= mod_nxt;
			mrd_r    <= mrd_nxt;
			aof_r    <= aof_nxt;
			wl_r     <= wl_nxt;
			lock_r   <= lock_nxt;
			err_r    <= err_nxt;
			ctl_r    <= ctl_nxt;
			odt_r    <= odt_nxt;
			dqs_oe_r <= dqs_oe_nxt;
			dqs_r    <= dqs_nxt;
			dqs1_r   <= lnk.dqs;
			dqs2_r   <= dqs1_r;
			dqs3_r   <= dqs2_r;
			dq1_r    <= lnk.dq;
			dq2_r    <= dq1_r;
			left_r   <= left_nxt;
			idx_r    <= idx_nxt;
			rdv_r    <= rdv_nxt;
			rb_r     <= rb_nxt;
			prd_r    <= prd_nxt;
		end
	end

	assign prdata       = prd_r;
	assign lnk.ck       = ck_r;
	assign lnk.cs_n     = 1'b0;
	assign lnk.ras_n    = cmd_r[2];
	assign lnk.cas_n    = cmd_r[1];
	assign lnk.we_n     = cmd_r[0];
	assign lnk.ba       = ba_r;
	assign lnk.addr     = out_a_r;
	assign lnk.odt      = odt_r;
	assign lnk.dqs_c_o  = dqs_r;
	assign lnk.dqs_c_oe = dqs_oe_r;
endmodule : ddr_ctrl_end

// *** rtl/ddr_dram_end.sv ***
`timescale 1ns/1ps
module ddr_dram_end #(
	parameter int DQ_W = 16,
	parameter int TMOD = ddr_link_pkg::TMOD_CK
)(
	// System
	input  logic            clk,
	input  logic            reset_n,
	input  logic            ce,
	// Array side
	input  logic            dll_locked,
	input  logic [DQ_W-1:0] rd_word,
	output logic [2:0]      rd_bank,
	output logic [9:0]      rd_col,
	output logic            wl_mode,
	// Link
	ddr_link_if.dram        lnk
);
	localparam int P = ddr_link_pkg::PIPE;

	logic [23:0] s1_r, s2_r;
	logic        ck3_r, dqs3_r;
	logic [3:0]  ph_r, ph_nxt;
	logic        rise, bnd, mid;
	logic [2:0]  cmd;
	logic [13:0] a;
	logic [13:0] mr0_r, mr0_nxt, mr1_r, mr1_nxt;
	logic [4:0]  rl;
	logic [5:0]  mod_r, mod_nxt;
	logic        fb_r, fb_nxt;
	logic [P-1:0] pv_r, pv_nxt;
	logic [3:0]  pn_r [P], pn_nxt [P];
	logic [2:0]  pb_r [P], pb_nxt [P];
	logic [9:0]  pc_r [P], pc_nxt [P];
	logic [3:0]  left_r, left_nxt;
	logic [2:0]  beat_r, beat_nxt, bank_r, bank_nxt;
	logic [9:0]  base_r, base_nxt, col_r, col_nxt;
	logic        dqs_oe_r, dqs_oe_nxt, dqs_r, dqs_nxt;
	logic        dq_oe_r;
	logic [DQ_W-1:0] dq_r;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s1_r   <= 24'h000000;
			s2_r   <= 24'h000000;
			ck3_r  <= 1'b0;
			dqs3_r <= 1'b0;
		end else if (ce) begin
			s1_r   <= {lnk.ck, lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n, lnk.odt, lnk.ba,
				lnk.addr, lnk.dqs};
			s2_r   <= s1_r;
			ck3_r  <= s2_r[23];
			dqs3_r <= s2_r[0];
		end
	end

	assign rise = s2_r[23] & ~ck3_r;
	assign cmd  = s2_r[22] ? ddr_link_pkg::CMD_NOP : s2_r[21:19];
	assign a    = s2_r[14:1];
	assign bnd  = rise | (ph_r == 4'(ddr_link_pkg::CK_HALF - 1));
	assign mid  = (ph_r == 4'(ddr_link_pkg::CK_HALF / 2 - 1)) ||
		(ph_r == 4'(ddr_link_pkg::CK_HALF + ddr_link_pkg::CK_HALF / 2 - 1));
	assign rl   = ddr_link_pkg::rl_of(mr1_r[ddr_link_pkg::MR1_AL +: 2],
		mr0_r[ddr_link_pkg::MR0_CL +: 4]);
	assign wl_mode = mr1_r[ddr_link_pkg::MR1_WL];

	// Mode registers and leveling
	always_comb begin
		ph_nxt  = rise ? 4'h0 : ((ph_r == 4'hf) ? ph_r : ph_r + 4'h1);
		mr0_nxt = mr0_r;
		mr1_nxt = mr1_r;
		mod_nxt = (rise && mod_r != 6'h00) ? mod_r - 6'h01 : mod_r;
		fb_nxt  = (wl_mode && s2_r[0] && !dqs3_r) ? s2_r[23] : fb_r;
		if (rise && cmd == ddr_link_pkg::CMD_MRS) begin
			if (s2_r[17:15] == ddr_link_pkg::BA_MR0)
				mr0_nxt = a;
			if (s2_r[17:15] == ddr_link_pkg::BA_MR1) begin
				mr1_nxt = a;
				if (wl_mode && !a[ddr_link_pkg::MR1_WL])
					mod_nxt = 6'(TMOD);
			end
		end
	end

	// Read pipeline, one slot per link cycle since the command
	always_comb begin
		pv_nxt = pv_r;
		pn_nxt = pn_r;
		pb_nxt = pb_r;
		pc_nxt = pc_r;
		if (rise) begin
			for (int i = P - 1; i > 0; i--) begin
				pv_nxt[i] = pv_r[i-1];
				pn_nxt[i] = pn_r[i-1];
				pb_nxt[i] = pb_r[i-1];
				pc_nxt[i] = pc_r[i-1];
			end
			// Reads without a locked delay loop would come back at no defined time
			pv_nxt[0] = (cmd == ddr_link_pkg::CMD_RD) && dll_locked && !wl_mode;
			pn_nxt[0] = ddr_link_pkg::beats_of(mr0_r[1:0], a[ddr_link_pkg::A_BL]);
			pb_nxt[0] = s2_r[17:15];
			pc_nxt[0] = a[9:0];
		end
	end

	// Burst engine
	always_comb begin
		left_nxt   = left_r;
		beat_nxt   = beat_r;
		bank_nxt   = bank_r;
		base_nxt   = base_r;
		dqs_oe_nxt = dqs_oe_r;
		dqs_nxt    = (mid && left_r != 4'h0) ? ~dqs_r : dqs_r;
		if (bnd && left_r != 4'h0) begin
			left_nxt = left_r - 4'h1;
			beat_nxt = beat_r + 3'h1;
			if (left_r == 4'h1)
				dqs_oe_nxt = 1'b0;
		end
		if (rise && pv_r[5'(rl - 5'h02)]) begin
			dqs_oe_nxt = 1'b1;
			dqs_nxt    = 1'b0;
		end
		if (rise && pv_r[5'(rl - 5'h01)]) begin
			left_nxt   = pn_r[5'(rl - 5'h01)];
			beat_nxt   = 3'h0;
			bank_nxt   = pb_r[5'(rl - 5'h01)];
			base_nxt   = pc_r[5'(rl - 5'h01)];
			dqs_oe_nxt = 1'b1;
		end
		col_nxt = {base_nxt[9:3], base_nxt[2:0] + beat_nxt};
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ph_r     <= 4'h0;
			mr0_r    <= 14'h0000;
			mr1_r    <= 14'h0000;
			mod_r    <= 6'h00;
			fb_r     <= 1'b0;
			pv_r     <= '0;
			left_r   <= 4'h0;
			beat_r   <= 3'h0;
			bank_r   <= 3'h0;
			base_r   <= 10'h000;
			col_r    <= 10'h000;
			dqs_oe_r <= 1'b0;
			dqs_r    <= 1'b0;
			dq_oe_r  <= 1'b0;
			dq_r     <= '0;
			for (int i = 0; i < P; i++) begin
				pn_r[i] <= 4'h0;
				pb_r[i] <= 3'h0;
				pc_r[i] <= 10'h000;
			end
		end else if (ce) begin
			ph_r     <= ph_nxt;
			mr0_r    <= mr0_nxt;
			mr1_r    <= mr1_nxt;
			mod_r    <= mod_nxt;
			fb_r     <= fb_nxt;
			pv_r     <= pv_nxt;
			pn_r     <= pn_nxt;
			pb_r     <= pb_nxt;
			pc_r     <= pc_nxt;
			left_r   <= left_nxt;
			beat_r   <= beat_nxt;
			bank_r   <= bank_nxt;
			base_r   <= base_nxt;
			col_r    <= col_nxt;
			dqs_oe_r <= dqs_oe_nxt;
			dqs_r    <= dqs_nxt;
			// Pins keep driving the leveling result until the mode delay is over
			dq_oe_r  <= (left_nxt != 4'h0) || wl_mode || (mod_r != 6'h00);
			dq_r     <= (wl_mode || mod_r != 6'h00) ? {DQ_W{fb_r}} : rd_word;
		end
	end

	assign rd_bank      = bank_r;
	assign rd_col       = col_r;
	assign lnk.dqs_d_o  = dqs_r;
	assign lnk.dqs_d_oe = dqs_oe_r;
	assign lnk.dq_d_o   = dq_r;
	assign lnk.dq_d_oe  = dq_oe_r;
endmodule : ddr_dram_end

// *** tb/ddr3_read_burst_wl_exit_tb.sv ***
`timescale 1ns/1ps
module ddr3_read_burst_wl_exit_tb;
	logic        clk;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        dll_locked;
	logic        wl_mode;
	logic [2:0]  rd_bank;
	logic [9:0]  rd_col;
	logic [31:0] q;
	logic        e;
	int          num_errors = 0;
	int          n_checks   = 0;
	int          cyc        = 0;
	int          t_rd       = 0;
	int          lat        = 0;
	int          lat5;
	ddr_link_if lnk ();
	ddr_ctrl_end ddr_ctrl_end_i (.clk(clk), .reset_n(reset_n), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lnk(lnk));
	ddr_dram_end ddr_dram_end_i (.clk(clk), .reset_n(reset_n), .ce(1'b1),
		.dll_locked(dll_locked), .rd_word({3'h0, rd_bank, rd_col}), .rd_bank(rd_bank),
		.rd_col(rd_col), .wl_mode(wl_mode), .lnk(lnk));
	ddr_link_sva ddr_link_sva_i (.clk(clk), .reset_n(reset_n), .ck(lnk.ck), .ras_n(lnk.ras_n),
		.cas_n(lnk.cas_n), .we_n(lnk.we_n), .odt(lnk.odt), .ba(lnk.ba), .addr(lnk.addr),
		.dqs_c_oe(lnk.dqs_c_oe), .dqs_d_oe(lnk.dqs_d_oe), .dq_d_oe(lnk.dq_d_oe));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Read latency is measured from the link rise carrying the read
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if ($rose(lnk.ck) && {lnk.ras_n, lnk.cas_n, lnk.we_n} == ddr_link_pkg::CMD_RD)
			t_rd <= cyc;
		if ($rose(lnk.dqs_d_oe))
			lat <= cyc - t_rd;
		if (cyc == 60000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] cw(input logic [2:0] o, input logic [2:0] b,
		input logic [13:0] a);
		return {2'h0, a, 9'h000, b, 1'b0, o};
	endfunction : cw
	task automatic cmd(input logic [2:0] o, input logic [2:0] b, input logic [13:0] a);
		apb(1'b1, ddr_link_pkg::REG_CMD, cw(o, b, a));
		chk({31'h0, e}, 32'h0);
		do
			apb(1'b0, ddr_link_pkg::REG_STAT, 32'h0);
		while (q[0] !== 1'b0);
	endtask : cmd
	// Aligned to a link fall, a second order lands while the read waits
	task automatic burst(input logic [2:0] b, input logic [13:0] a, input int n);
		logic [9:0] c;
		c = a[9:0];
		@(negedge lnk.ck);
		apb(1'b1, ddr_link_pkg::REG_CMD, cw(ddr_link_pkg::CMD_RD, b, a));
		apb(1'b1, ddr_link_pkg::REG_CMD, cw(ddr_link_pkg::CMD_PRE, b, 14'h0000));
		chk({31'h0, e}, 32'h1);
		do
			apb(1'b0, ddr_link_pkg::REG_STAT, 32'h0);
		while (q[3] !== 1'b1 || q[0] !== 1'b0);
		for (int k = 0; k < n; k++) begin
			apb(1'b0, ddr_link_pkg::REG_RDATA + 8'(4 * k), 32'h0);
			chk(q, {3'h0, b, c[9:3], 3'(c[2:0] + 2 * k + 1), 3'h0, b, c[9:3], 3'(c[2:0] + 2 * k)});
		end
	endtask : burst
	task automatic t_unmapped;
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
	endtask : t_unmapped
	task automatic t_level;
		int t0;
		cmd(ddr_link_pkg::CMD_MRS, ddr_link_pkg::BA_MR1, 14'h0080);
		for (int i = 0; i < 64 && wl_mode !== 1'b1; i++)
			@(posedge clk);
		chk({31'h0, wl_mode}, 32'h1);
		t0 = t_rd;
		cmd(ddr_link_pkg::CMD_RD, 3'h2, 14'h0000);
		apb(1'b0, ddr_link_pkg::REG_STAT, 32'h0);
		chk({29'h0, q[2:0]}, 32'h6);
		chk(t_rd, t0);
		apb(1'b1, ddr_link_pkg::REG_CTRL, 32'h3);
		cmd(ddr_link_pkg::OP_WLX, 3'h0, 14'h0000);
		for (int i = 0; i < 64 && wl_mode !== 1'b0; i++)
			@(posedge clk);
		chk({31'h0, wl_mode}, 32'h0);
		chk({30'h0, lnk.odt, lnk.dqs_c_oe}, 32'h0);
		apb(1'b0, ddr_link_pkg::REG_STAT, 32'h0);
		chk({29'h0, q[2:0]}, 32'h0);
	endtask : t_level
	task automatic t_bl8;
		cmd(ddr_link_pkg::CMD_MRS, ddr_link_pkg::BA_MR1, 14'h0000);
		cmd(ddr_link_pkg::CMD_MRS, ddr_link_pkg::BA_MR0, 14'h0051);
		cmd(ddr_link_pkg::CMD_ACT, 3'h2, 14'h0005);
		burst(3'h2, 14'h1008, 4);
		lat5 = lat;
	endtask : t_bl8
	task automatic t_chop;
		dll_locked <= 1'b0;
		cmd(ddr_link_pkg::CMD_RD, 3'h2, 14'h1000);
		repeat (120) @(posedge clk);
		apb(1'b0, ddr_link_pkg::REG_STAT, 32'h0);
		chk({31'h0, q[3]}, 32'h0);
		dll_locked <= 1'b1;
		burst(3'h2, 14'h0004, 2);
	endtask : t_chop
	task automatic t_al;
		cmd(ddr_link_pkg::CMD_MRS, ddr_link_pkg::BA_MR1, 14'h0008);
		cmd(ddr_link_pkg::CMD_MRS, ddr_link_pkg::BA_MR0, 14'h0050);
		burst(3'h2, 14'h0010, 4);
		chk(lat - lat5, 32);
	endtask : t_al
	task automatic t_pre;
		cmd(ddr_link_pkg::CMD_PRE, 3'h2, 14'h0000);
		cmd(ddr_link_pkg::CMD_ACT, 3'h2, 14'h0009);
		cmd(ddr_link_pkg::CMD_PRE, 3'h2, 14'h0000);
	endtask : t_pre
	initial begin
		reset_n    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 8'h00;
		pwdata     = 32'h0;
		dll_locked = 1'b1;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		// The device needs a few link clocks before its first command
		repeat (32) @(posedge clk);
		t_unmapped();
		t_level();
		t_bl8();
		t_chop();
		t_al();
		t_pre();
		stop_test();
	end
endmodule : ddr3_read_burst_wl_exit_tb

// *** tb/ddr_link_sva.sv ***
`timescale 1ns/1ps
module ddr_link_sva (
	// System
	input logic        clk,
	input logic        reset_n,
	// Link
	input logic        ck,
	input logic        ras_n,
	input logic        cas_n,
	input logic        we_n,
	input logic        odt,
	input logic [2:0]  ba,
	input logic [13:0] addr,
	input logic        dqs_c_oe,
	input logic        dqs_d_oe,
	input logic        dq_d_oe
);
	localparam int K = 2 * ddr_link_pkg::CK_HALF;
	logic [2:0]  cmd;
	logic        ck_r;
	logic        hit;
	logic [11:0] gap_r [4];
	logic [11:0] gap_nxt [4];
	logic [6:0]  str_r;
	logic [6:0]  str_nxt;
	assign cmd = {ras_n, cas_n, we_n};
	// A command counts once, at the link rise where the device takes it
	assign hit = ck && !ck_r;
	// Gaps saturate so a long idle never wraps into a false short spacing
	always_comb begin
		for (int i = 0; i < 4; i++)
			gap_nxt[i] = (gap_r[i] == 12'hfff) ? gap_r[i] : gap_r[i] + 12'h001;
		if (hit)
			case (cmd)
				ddr_link_pkg::CMD_ACT: gap_nxt[0] = 12'h000;
				ddr_link_pkg::CMD_PRE: gap_nxt[1] = 12'h000;
				ddr_link_pkg::CMD_RD:  gap_nxt[2] = 12'h000;
				ddr_link_pkg::CMD_MRS: gap_nxt[3] = 12'h000;
				default: ;
			endcase
		str_nxt = dqs_d_oe ? str_r + 7'h01 : 7'h00;
	end
	always_ff @(posedge clk) begin
		ck_r <= ck;
		if (!reset_n) begin
			str_r <= 7'h00;
			gap_r <= '{default: 12'hfff};
		end else begin
			str_r <= str_nxt;
			gap_r <= gap_nxt;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_PRE_TRAS: assert property (hit && cmd == ddr_link_pkg::CMD_PRE
		|-> gap_r[0] >= K * ddr_link_pkg::TRAS_CK - 1) else $error("precharge early after activate");
	AST_PRE_TRTP: assert property (hit && cmd == ddr_link_pkg::CMD_PRE
		|-> gap_r[2] >= K * ddr_link_pkg::TRTP_CK - 1) else $error("precharge early after read");
	AST_ACT_TRP: assert property (hit && cmd == ddr_link_pkg::CMD_ACT
		|-> gap_r[1] >= K * ddr_link_pkg::TRP_CK - 1) else $error("activate early after precharge");
	AST_ACT_TRC: assert property (hit && cmd == ddr_link_pkg::CMD_ACT
		|-> gap_r[0] >= K * ddr_link_pkg::TRC_CK - 1) else $error("activate early after activate");
	AST_CMD_TMOD: assert property (hit && cmd inside {3'h2, 3'h3, 3'h5}
		|-> gap_r[3] >= K * ddr_link_pkg::TMOD_CK - 1) else $error("command early after mode set");
	AST_MRS_TMRD: assert property (hit && cmd == ddr_link_pkg::CMD_MRS
		|-> gap_r[3] >= K * ddr_link_pkg::TMRD_CK - 1) else $error("mode sets too close");
	AST_EXIT_QUIET: assert property (hit && cmd == ddr_link_pkg::CMD_MRS && ba == 3'h1
		&& !addr[7] |-> !odt && !dqs_c_oe) else $error("leveling off with termination on");
	AST_DATA_AT_RL: assert property ($rose(dq_d_oe) && dqs_d_oe |-> str_r == K)
		else $error("data not one clock after strobe");
	AST_RELEASE: assert property ($fell(dqs_d_oe) |-> !dq_d_oe
		&& (str_r == 5 * K || str_r == 3 * K)) else $error("bad burst release");
	AST_NO_CLASH: assert property (!(dqs_c_oe && dqs_d_oe))
		else $error("both ends drive strobe");
	cover property (hit && cmd == ddr_link_pkg::CMD_MRS && ba == 3'h1 && !addr[7]);
	cover property ($fell(dqs_d_oe) && str_r == 5 * K);
	cover property ($fell(dqs_d_oe) && str_r == 3 * K);
endmodule : ddr_link_sva
